// ---- logic/snr_pkg.sv ----
// package for the serial nand command block: opcodes, feature map,
// apb register map, timing counts and the shared link structs.
// assumes a 40 MHz pclk and a host that drives the link pins.
package snr_pkg;

  // ----------------------------------------
  // link opcodes
  // ----------------------------------------
  localparam logic [7:0] OP_WRITE_LATCH_SET = 8'h06;
  localparam logic [7:0] OP_WRITE_LATCH_CLEAR = 8'h04;
  localparam logic [7:0] OP_GET_FEATURE = 8'h0f;
  localparam logic [7:0] OP_SET_FEATURE = 8'h1f;
  localparam logic [7:0] OP_PAGE_READ = 8'h13;
  localparam logic [7:0] OP_PROGRAM_EXEC = 8'h10;
  localparam logic [7:0] OP_BLOCK_ERASE = 8'hd8;
  localparam logic [7:0] OP_RESET = 8'hff;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_FAST_READ = 8'h0b;
  localparam logic [7:0] OP_READ_X2 = 8'h3b;
  localparam logic [7:0] OP_READ_X4 = 8'h6b;
  localparam logic [7:0] OP_READ_DUAL_IO = 8'hbb;
  localparam logic [7:0] OP_READ_QUAD_IO = 8'heb;
  localparam logic [7:0] OP_READ_DTR_QUAD = 8'hee;
  localparam logic [7:0] OP_READ_DTR_QUAD4 = 8'hed;

  // ----------------------------------------
  // feature registers
  // ----------------------------------------
  localparam logic [7:0] FEAT_PROTECT = 8'ha0;
  localparam logic [7:0] FEAT_CONFIG = 8'hb0;
  localparam logic [7:0] FEAT_STATUS = 8'hc0;
  localparam int CFG_QE_BIT = 0;
  localparam int CFG_NR_BIT = 1;
  localparam int CFG_DC_BIT = 2;
  localparam int CFG_CONTINUOUS_DUMMY_SELECT_BIT = 3;
  localparam int CFG_ECC_BIT = 4;
  localparam int STAT_OIP_BIT = 0;
  localparam int STAT_WEL_BIT = 1;
  localparam logic [7:0] CFG_RESET = 8'h12;
  localparam logic [7:0] PROTECT_RESET = 8'h00;

  // ----------------------------------------
  // cache geometry
  // ----------------------------------------
  localparam int CACHE_AW = 12;
  localparam int CACHE_DEPTH = 2176;
  localparam logic [11:0] SPARE_END = 12'h840;
  localparam logic [11:0] ECC_END = 12'h880;

  // ----------------------------------------
  // apb map
  // ----------------------------------------
  localparam logic [11:0] REG_STATUS = 12'h000;
  localparam logic [11:0] REG_PAGE_ADDR = 12'h004;
  localparam logic [11:0] REG_CACHE_ADDR = 12'h008;
  localparam logic [11:0] REG_CACHE_DATA = 12'h00c;
  localparam logic [11:0] REG_CONFIG = 12'h010;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int ARRAY_READ_BUSY_TIME_NS = 25000;
  localparam logic [15:0] ARRAY_READ_BUSY_CYCLES =
    16'((ARRAY_READ_BUSY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_OPCODE = 6'h02,
    ST_ARG = 6'h04,
    ST_PRE = 6'h08,
    ST_DOUT = 6'h10,
    ST_IGNORE = 6'h20
  } snr_state_type;

  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic [3:0] io;
  } snr_link_in_type;

  typedef struct packed {
    logic [3:0] io_out;
    logic [3:0] io_oe;
  } snr_link_out_type;

endpackage : snr_pkg

// ---- logic/snr_cache_mem.sv ----
// cache register storage: one write port, one registered read port.
// assumes both ports on pclk; read data lags the address by one edge.
`timescale 1ns/10ps
module snr_cache_mem (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // write port
  input wire logic we,
  input wire logic [11:0] waddr,
  input wire logic [7:0] wdata,
  // read port
  input wire logic [11:0] raddr,
  output logic [7:0] rdata
);

  logic [7:0] mem [0:snr_pkg::CACHE_DEPTH-1];

  always_ff @(posedge pclk) begin
    if (we && (int'(waddr) < snr_pkg::CACHE_DEPTH)) begin
      mem[waddr] <= wdata;
    end
  end

  // out of range reads return zero rather than an unknown word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata <= 8'h00;
    end else if (int'(raddr) < snr_pkg::CACHE_DEPTH) begin
      rdata <= mem[raddr];
    end else begin
      rdata <= 8'h00;
    end
  end

endmodule : snr_cache_mem

// ---- logic/snr_core.sv ----
// serial nand command front end: latch, features, page read, cache reads.
// assumes the host drives chip select, serial clock and io pins, slow
// enough that pclk sees every level; software fills the cache over apb.
//
// The APB register port and the address map are this design's own decisions.
`timescale 1ns/10ps
module snr_core (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial link pins
  input wire snr_pkg::snr_link_in_type link_in,
  output snr_pkg::snr_link_out_type link_out
);

  typedef struct packed {
    snr_pkg::snr_link_in_type sy1;
    snr_pkg::snr_link_in_type sy2;
    logic sclk_d;
    snr_pkg::snr_state_type st;
    logic [7:0] op;
    logic [5:0] bits;
    logic [23:0] sh;
    logic [5:0] pre_total;
    logic [2:0] lanes;
    logic feat_out;
    logic [11:0] col;
    logic [7:0] dbyte;
    logic [2:0] dcnt;
    logic [7:0] feat_addr;
    logic [7:0] protect;
    logic [7:0] cfg;
    logic write_enable_latch;
    logic operation_in_progress;
    logic [15:0] busy_cnt;
    logic [23:0] page_addr;
    logic [3:0] io_out;
    logic [3:0] io_oe;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [11:0] cache_addr;
    logic mem_we;
    logic [11:0] mem_waddr;
    logic [7:0] mem_wdata;
  } snr_core_type;

  snr_core_type r;
  snr_core_type next_r;
  logic [7:0] mem_rdata;

  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  function automatic logic is_quad_op(input logic [7:0] op);
    return (op == snr_pkg::OP_READ_X4) || (op == snr_pkg::OP_READ_QUAD_IO) ||
           (op == snr_pkg::OP_READ_DTR_QUAD) || (op == snr_pkg::OP_READ_DTR_QUAD4);
  endfunction : is_quad_op

  function automatic logic is_cache_read(input logic [7:0] op);
    return (op == snr_pkg::OP_READ) || (op == snr_pkg::OP_FAST_READ) ||
           (op == snr_pkg::OP_READ_X2) || (op == snr_pkg::OP_READ_DUAL_IO) ||
           is_quad_op(op);
  endfunction : is_cache_read

  // lines used for the address clocks: 1, 2 or 4; data lines come from out_lanes
  function automatic logic [2:0] in_lanes(input logic [7:0] op);
    if (op == snr_pkg::OP_READ_DUAL_IO) return 3'd2;
    if (op == snr_pkg::OP_READ_QUAD_IO || op == snr_pkg::OP_READ_DTR_QUAD ||
        op == snr_pkg::OP_READ_DTR_QUAD4) return 3'd4;
    return 3'd1;
  endfunction : in_lanes

  function automatic logic [2:0] out_lanes(input logic [7:0] op);
    if (op == snr_pkg::OP_READ_X2) return 3'd2;
    if (is_quad_op(op)) return 3'd4;
    return in_lanes(op);
  endfunction : out_lanes

  // clocks between opcode and first data, per read mode
  function automatic logic [5:0] pre_clocks(input logic [7:0] op, input logic [7:0] cfg);
    logic nr;
    logic continuous_dummy_select;
    logic dc;
    logic io_dual;
    logic io_quad;
    nr = cfg[snr_pkg::CFG_NR_BIT];
    continuous_dummy_select = cfg[snr_pkg::CFG_CONTINUOUS_DUMMY_SELECT_BIT];
    dc = cfg[snr_pkg::CFG_DC_BIT];
    io_dual = (op == snr_pkg::OP_READ_DUAL_IO);
    io_quad = (in_lanes(op) == 3'd4);
    if (!nr && !continuous_dummy_select) begin
      if (io_dual) return 6'd16;
      if (io_quad) return 6'd12;
      if (op == snr_pkg::OP_READ) return 6'd24;
      return 6'd32;
    end
    if (io_dual) return dc ? 6'd16 : 6'd12;
    if (io_quad) return dc ? 6'd12 : 6'd8;
    return 6'd24;
  endfunction : pre_clocks

  function automatic logic [23:0] shift_in(input logic [23:0] sh, input logic [3:0] io,
                                           input logic [2:0] lanes);
    if (lanes == 3'd4) return {sh[19:0], io};
    if (lanes == 3'd2) return {sh[21:0], io[1:0]};
    return {sh[22:0], io[0]};
  endfunction : shift_in

  // top bits of a byte placed on the output lines
  function automatic logic [3:0] top_bits(input logic [7:0] b, input logic [2:0] lanes);
    if (lanes == 3'd4) return b[7:4];
    if (lanes == 3'd2) return {2'b00, b[7:6]};
    return {2'b00, b[7], 1'b0};
  endfunction : top_bits

  function automatic logic [3:0] lane_oe(input logic [2:0] lanes);
    if (lanes == 3'd4) return 4'hf;
    if (lanes == 3'd2) return 4'h3;
    return 4'h2;
  endfunction : lane_oe

  // ----------------------------------------
  // link edges and shared terms
  // ----------------------------------------
  logic rise;
  logic fall;
  logic deselect;
  logic [7:0] op_now;
  logic [7:0] byte_now;
  logic [7:0] feat_val;
  logic [11:0] wrap_end;
  logic apb_access;
  logic apb_commit;

  assign rise = r.sy2.sclk & ~r.sclk_d & ~r.sy2.cs_n;
  assign fall = ~r.sy2.sclk & r.sclk_d & ~r.sy2.cs_n;
  assign deselect = r.sy2.cs_n;
  assign op_now = {r.sh[6:0], r.sy2.io[0]};
  assign byte_now = r.feat_out ? feat_val : mem_rdata;
  assign wrap_end = r.cfg[snr_pkg::CFG_ECC_BIT] ? snr_pkg::ECC_END : snr_pkg::SPARE_END;
  assign apb_access = psel & penable & ~r.pready;
  assign apb_commit = psel & penable & r.pready;

  always_comb begin
    feat_val = 8'h00;
    unique case (r.feat_addr)
      snr_pkg::FEAT_PROTECT: feat_val = r.protect;
      snr_pkg::FEAT_CONFIG: feat_val = r.cfg;
      snr_pkg::FEAT_STATUS: begin
        feat_val[snr_pkg::STAT_OIP_BIT] = r.operation_in_progress;
        feat_val[snr_pkg::STAT_WEL_BIT] = r.write_enable_latch;
      end
      default: feat_val = 8'h00;
    endcase
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    next_r = r;
    next_r.sy1 = link_in;
    next_r.sy2 = r.sy1;
    next_r.sclk_d = r.sy2.sclk;
    next_r.mem_we = 1'b0;

    // apb: one wait state, write lands on the completing edge
    next_r.pready = apb_access;
    if (apb_access) begin
      next_r.pslverr = 1'b0;
      unique case (paddr)
        snr_pkg::REG_STATUS: next_r.prdata = {28'h0, r.cfg[snr_pkg::CFG_QE_BIT],
          r.st == snr_pkg::ST_IDLE, r.write_enable_latch, r.operation_in_progress};
        snr_pkg::REG_PAGE_ADDR: next_r.prdata = {8'h00, r.page_addr};
        snr_pkg::REG_CACHE_ADDR: next_r.prdata = {20'h0, r.cache_addr};
        snr_pkg::REG_CACHE_DATA: next_r.prdata = 32'h0;
        snr_pkg::REG_CONFIG: next_r.prdata = {24'h0, r.cfg};
        default: begin
          next_r.prdata = 32'h0;
          next_r.pslverr = 1'b1;
        end
      endcase
    end
    if (apb_commit && pwrite) begin
      if (paddr == snr_pkg::REG_CACHE_ADDR) next_r.cache_addr = pwdata[11:0];
      if (paddr == snr_pkg::REG_CACHE_DATA) begin
        next_r.mem_we = 1'b1;
        next_r.mem_waddr = r.cache_addr;
        next_r.mem_wdata = pwdata[7:0];
        next_r.cache_addr = r.cache_addr + 12'd1;
      end
    end

    // internal operation timer
    if (r.operation_in_progress) begin
      next_r.busy_cnt = r.busy_cnt - 16'd1;
      if (r.busy_cnt <= 16'd1) next_r.operation_in_progress = 1'b0;
    end

    unique case (r.st)
      snr_pkg::ST_IDLE: begin
        if (!deselect) begin
          next_r.st = snr_pkg::ST_OPCODE;
          next_r.bits = 6'd0;
        end
      end
      snr_pkg::ST_OPCODE: begin
        if (rise) begin
          next_r.sh = shift_in(r.sh, r.sy2.io, 3'd1);
          next_r.bits = r.bits + 6'd1;
          if (r.bits == 6'd7) begin
            next_r.op = op_now;
            next_r.bits = 6'd0;
            next_r.st = snr_pkg::ST_IGNORE;
            if (op_now == snr_pkg::OP_RESET) begin
              next_r.write_enable_latch = 1'b0;
              next_r.operation_in_progress = 1'b0;
            end else if (op_now == snr_pkg::OP_GET_FEATURE) begin
              next_r.st = snr_pkg::ST_ARG;
            end else if (r.operation_in_progress) begin
              next_r.st = snr_pkg::ST_IGNORE;
            end else if (op_now == snr_pkg::OP_WRITE_LATCH_SET) begin
              next_r.write_enable_latch = 1'b1;
            end else if (op_now == snr_pkg::OP_WRITE_LATCH_CLEAR) begin
              next_r.write_enable_latch = 1'b0;
            end else if (op_now == snr_pkg::OP_SET_FEATURE || op_now == snr_pkg::OP_PAGE_READ ||
                         op_now == snr_pkg::OP_PROGRAM_EXEC ||
                         op_now == snr_pkg::OP_BLOCK_ERASE) begin
              next_r.st = snr_pkg::ST_ARG;
            end else if (is_cache_read(op_now)) begin
              if (!is_quad_op(op_now) || r.cfg[snr_pkg::CFG_QE_BIT]) begin
                next_r.st = snr_pkg::ST_PRE;
                next_r.pre_total = pre_clocks(op_now, r.cfg);
                next_r.lanes = in_lanes(op_now);
                next_r.feat_out = 1'b0;
              end
            end
          end
        end
      end
      snr_pkg::ST_ARG: begin
        if (rise) begin
          next_r.sh = shift_in(r.sh, r.sy2.io, 3'd1);
          next_r.bits = r.bits + 6'd1;
          if (r.op == snr_pkg::OP_GET_FEATURE && r.bits == 6'd7) begin
            next_r.feat_addr = op_now;
            next_r.feat_out = 1'b1;
            next_r.lanes = 3'd1;
            next_r.dcnt = 3'd0;
            next_r.st = snr_pkg::ST_DOUT;
          end else if (r.op == snr_pkg::OP_SET_FEATURE && r.bits == 6'd15) begin
            if (r.sh[14:7] == snr_pkg::FEAT_CONFIG) next_r.cfg = op_now;
            if (r.sh[14:7] == snr_pkg::FEAT_PROTECT) next_r.protect = op_now;
            next_r.st = snr_pkg::ST_IGNORE;
          end else if (r.bits == 6'd23) begin
            next_r.st = snr_pkg::ST_IGNORE;
            if (r.op == snr_pkg::OP_PAGE_READ) begin
              next_r.page_addr = {r.sh[22:0], r.sy2.io[0]};
              next_r.operation_in_progress = 1'b1;
              next_r.busy_cnt = snr_pkg::ARRAY_READ_BUSY_CYCLES;
            end else if (r.write_enable_latch) begin
              // array change starts; the latch drops with it
              next_r.page_addr = {r.sh[22:0], r.sy2.io[0]};
              next_r.operation_in_progress = 1'b1;
              next_r.busy_cnt = snr_pkg::ARRAY_READ_BUSY_CYCLES;
              next_r.write_enable_latch = 1'b0;
            end
            // latch clear: command dropped, array untouched
          end
        end
      end
      snr_pkg::ST_PRE: begin
        if (rise) begin
          // address clocks first; later clocks are dummies
          if (r.bits < 6'(16 / r.lanes)) next_r.sh = shift_in(r.sh, r.sy2.io, r.lanes);
          next_r.bits = r.bits + 6'd1;
          if (r.bits == r.pre_total - 6'd1) begin
            // continuous modes carry no address and start at column zero
            next_r.col = r.cfg[snr_pkg::CFG_NR_BIT] ? next_r.sh[11:0] : 12'h000;
            next_r.lanes = out_lanes(r.op);
            next_r.dcnt = 3'd0;
            next_r.st = snr_pkg::ST_DOUT;
          end
        end
      end
      snr_pkg::ST_DOUT: begin
        if (fall) begin
          next_r.io_oe = lane_oe(r.lanes);
          if (r.dcnt == 3'd0) begin
            next_r.io_out = top_bits(byte_now, r.lanes);
            next_r.dbyte = byte_now << r.lanes;
            next_r.dcnt = 3'(8 / r.lanes - 1);
            if (!r.feat_out) begin
              next_r.col = (r.col + 12'd1 == wrap_end) ? 12'h000 : r.col + 12'd1;
            end
          end else begin
            next_r.io_out = top_bits(r.dbyte, r.lanes);
            next_r.dbyte = r.dbyte << r.lanes;
            next_r.dcnt = r.dcnt - 3'd1;
          end
        end
      end
      snr_pkg::ST_IGNORE: begin
        next_r.st = snr_pkg::ST_IGNORE;
      end
      default: next_r.st = snr_pkg::ST_IDLE;
    endcase

    if (deselect && r.st != snr_pkg::ST_IDLE) begin
      next_r.st = snr_pkg::ST_IDLE;
      next_r.io_oe = 4'h0;
      next_r.io_out = 4'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.st <= snr_pkg::ST_IDLE;
      r.sy1.cs_n <= 1'b1;
      r.sy2.cs_n <= 1'b1;
      r.cfg <= snr_pkg::CFG_RESET;
      r.protect <= snr_pkg::PROTECT_RESET;
    end else begin
      r <= next_r;
    end
  end

  snr_cache_mem u_cache (
    .pclk(pclk),
    .presetn(presetn),
    .we(r.mem_we),
    .waddr(r.mem_waddr),
    .wdata(r.mem_wdata),
    .raddr(r.col),
    .rdata(mem_rdata)
  );

  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign link_out = '{io_out: r.io_out, io_oe: r.io_oe};

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic op_done;
  logic arg_done;
  assign op_done = (r.st == snr_pkg::ST_OPCODE) && rise && (r.bits == 6'd7) && !deselect;
  assign arg_done = (r.st == snr_pkg::ST_ARG) && rise && (r.bits == 6'd23) && !deselect &&
                    (r.op == snr_pkg::OP_PROGRAM_EXEC || r.op == snr_pkg::OP_BLOCK_ERASE);

  property p_latch_set;
    op_done && op_now == snr_pkg::OP_WRITE_LATCH_SET && !r.operation_in_progress
      |=> r.write_enable_latch;
  endproperty
  a_latch_set: assert property (p_latch_set) else $error("latch not set");

  property p_latch_clear;
    op_done && op_now == snr_pkg::OP_WRITE_LATCH_CLEAR && !r.operation_in_progress
      |=> !r.write_enable_latch;
  endproperty
  a_latch_clear: assert property (p_latch_clear) else $error("latch not cleared");

  property p_reset_cmd;
    op_done && op_now == snr_pkg::OP_RESET |=> !r.write_enable_latch && !r.operation_in_progress;
  endproperty
  a_reset_cmd: assert property (p_reset_cmd) else $error("reset left latch");

  property p_array_change;
    arg_done && r.write_enable_latch |=> !r.write_enable_latch && r.operation_in_progress;
  endproperty
  a_array_change: assert property (p_array_change) else $error("program did not run");

  property p_locked_out;
    arg_done && !r.write_enable_latch && !r.operation_in_progress |=> !r.operation_in_progress;
  endproperty
  a_locked_out: assert property (p_locked_out) else $error("locked program ran");

  property p_busy_hold;
    $rose(r.operation_in_progress) && r.op == snr_pkg::OP_PAGE_READ
      |-> r.operation_in_progress [*8] ##0 (r.busy_cnt > 16'd900);
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy too short");

  property p_quad_gate;
    op_done && is_quad_op(op_now) && !r.cfg[snr_pkg::CFG_QE_BIT]
      |=> r.st == snr_pkg::ST_IGNORE;
  endproperty
  a_quad_gate: assert property (p_quad_gate) else $error("quad read without enable");

  property p_column_step;
    r.st == snr_pkg::ST_DOUT && fall && !deselect && r.dcnt == 3'd0 && !r.feat_out
      |=> r.col == (($past(r.col) + 12'd1 == wrap_end) ? 12'h000 : $past(r.col) + 12'd1);
  endproperty
  a_column_step: assert property (p_column_step) else $error("column did not step");

  property p_ecc_wrap;
    r.cfg[snr_pkg::CFG_ECC_BIT] && r.st == snr_pkg::ST_DOUT && r.col == 12'h83f && fall &&
      !deselect && r.dcnt == 3'd0 |=> r.col == 12'h840;
  endproperty
  a_ecc_wrap: assert property (p_ecc_wrap) else $error("spare area wrapped");

  property p_deselect;
    deselect ##1 deselect |=> r.st == snr_pkg::ST_IDLE && r.io_oe == 4'h0;
  endproperty
  a_deselect: assert property (p_deselect) else $error("link not released");

  c_page_read: cover property (arg_done or (r.op == snr_pkg::OP_PAGE_READ &&
    $rose(r.operation_in_progress)));
  c_quad_out: cover property (r.st == snr_pkg::ST_DOUT && r.io_oe == 4'hf);
  c_dual_out: cover property (r.st == snr_pkg::ST_DOUT && r.io_oe == 4'h3);
  c_feature_poll: cover property (r.feat_out && r.operation_in_progress && fall);

endmodule : snr_core

// ---- bench/snr_host_model.sv ----
// host side of the serial link: chip select, sclk and io frames.
// assumes 40 MHz pclk; sclk low 5 and high 3 pclk cycles (200 ns).
`timescale 1ns/10ps
module snr_host_model (
  // system clock
  input wire logic pclk,
  // link pins
  output snr_pkg::snr_link_in_type link_in,
  input wire snr_pkg::snr_link_out_type link_out
);
  logic cs_n = 1'b1;
  logic sclk = 1'b0;
  logic [3:0] hv = 4'h0;
  logic [3:0] lvl;
  // during data clocks released lines show the inverse of the last level, never a stale copy
  assign lvl = (link_out.io_oe & link_out.io_out) | (~link_out.io_oe & hv);
  assign link_in = '{cs_n: cs_n, sclk: sclk, io: lvl};

  task automatic clk_bit(input logic [3:0] v, output logic [3:0] s);
    hv <= v;
    repeat (5) @(posedge pclk);
    s = lvl;
    sclk <= 1'b1;
    repeat (3) @(posedge pclk);
    sclk <= 1'b0;
  endtask : clk_bit

  task automatic xfer(input logic [7:0] op, input logic [23:0] arg, input int ab,
                      input int inl, input int dum, input int outl, input int nb,
                      output logic [31:0] rd);
    logic [3:0] s;
    logic [23:0] a;
    int i;
    cs_n <= 1'b0;
    repeat (4) @(posedge pclk);
    for (i = 7; i >= 0; i--) clk_bit({3'h0, op[i]}, s);
    a = arg << (24 - ab);
    for (i = 0; i < ab / inl; i++) begin
      clk_bit(4'(a[23 -: 4] >> (4 - inl)), s);
      a = a << inl;
    end
    for (i = 0; i < dum; i++) clk_bit(4'h0, s);
    rd = 32'h0;
    for (i = 0; i < nb * 8 / outl; i++) begin
      clk_bit(~s, s);
      rd = (outl == 1) ? {rd[30:0], s[1]} : (outl == 2) ? {rd[29:0], s[1:0]} : {rd[27:0], s};
    end
    repeat (4) @(posedge pclk);
    cs_n <= 1'b1;
    repeat (6) @(posedge pclk);
  endtask : xfer
endmodule : snr_host_model

// ---- bench/testbench.sv ----
// self-checking bench for snr_core: apb tasks and host link frames.
// assumes snr_host_model on the link pins and a 40 MHz pclk.
`timescale 1ns/10ps
module testbench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, e;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r, lr;
  logic [47:0] dat = 48'ha53c965ac30f;
  snr_pkg::snr_link_in_type link_in;
  snr_pkg::snr_link_out_type link_out;
  int checks = 0, mismatches = 0, cyc = 0, oe_cnt = 0, k, n;
  logic [7:0] ops[12] = '{8'h03, 8'h0b, 8'h3b, 8'h6b, 8'hbb, 8'heb, 8'hbb, 8'heb, 8'hee,
                          8'hed, 8'h03, 8'hbb};
  logic [7:0] cfg[12] = '{8'h13, 8'h13, 8'h13, 8'h13, 8'h13, 8'h13, 8'h17, 8'h17, 8'h13,
                          8'h03, 8'h11, 8'h1d};
  int inl[12] = '{1, 1, 1, 1, 2, 4, 2, 4, 4, 4, 1, 2};
  int dum[12] = '{8, 8, 8, 8, 4, 4, 8, 8, 4, 4, 24, 16};
  int outl[12] = '{1, 1, 2, 4, 2, 4, 2, 4, 4, 4, 1, 2};

  always #12.5 pclk = ~pclk;

  snr_core DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link_in(link_in), .link_out(link_out));
  snr_host_model host (.pclk(pclk), .link_in(link_in), .link_out(link_out));

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test

  // cut a hang short after far more cycles than the run needs
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (link_out.io_oe !== 4'h0) oe_cnt <= oe_cnt + 1;
    if (cyc == 60000) begin
      mismatches++;
      finish_test();
    end
  end

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    checks++;
    if (got !== ex) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // this wait ends on pready; if pready never comes, only the bench timeout ends it
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] ex);
    apb(1'b0, a, 32'h0);
    chk(nm, ex, r);
  endtask : rdchk

  task automatic lk(input logic [7:0] op, input logic [23:0] arg, input int ab, input int nb);
    host.xfer(op, arg, ab, 1, 0, 1, nb, lr);
  endtask : lk

  task automatic wait_idle;
    do apb(1'b0, snr_pkg::REG_STATUS, 32'h0); while (r[0] !== 1'b0);
  endtask : wait_idle

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("io_oe", 32'h0, {28'h0, link_out.io_oe});
    rdchk("status", snr_pkg::REG_STATUS, 32'h4);
    rdchk("config", snr_pkg::REG_CONFIG, 32'h12);
    apb(1'b0, 12'h020, 32'h0);
    chk("pslverr", 32'h1, {31'h0, e});
    lk(8'h06, 24'h0, 0, 0);
    rdchk("latch set", snr_pkg::REG_STATUS, 32'h6);
    lk(8'h0f, 24'hc0, 8, 1);
    chk("get status", 32'h2, lr);
    lk(8'h04, 24'h0, 0, 0);
    rdchk("latch clear", snr_pkg::REG_STATUS, 32'h4);
    lk(8'h06, 24'h0, 0, 0);
    lk(8'hff, 24'h0, 0, 0);
    rdchk("reset clear", snr_pkg::REG_STATUS, 32'h4);
    lk(8'h10, 24'h000123, 24, 0);
    rdchk("no program", snr_pkg::REG_PAGE_ADDR, 32'h0);
    lk(8'h06, 24'h0, 0, 0);
    lk(8'h10, 24'h000123, 24, 0);
    rdchk("program", snr_pkg::REG_PAGE_ADDR, 32'h123);
    wait_idle();
    rdchk("latch after", snr_pkg::REG_STATUS, 32'h4);
    lk(8'h13, 24'h000456, 24, 0);
    rdchk("busy", snr_pkg::REG_STATUS, 32'h5);
    lk(8'h0f, 24'hc0, 8, 1);
    chk("busy poll", 32'h1, lr);
    wait_idle();
    rdchk("page addr", snr_pkg::REG_PAGE_ADDR, 32'h456);
    for (k = 0; k < 6; k++) begin
      if (k % 3 == 0) apb(1'b1, snr_pkg::REG_CACHE_ADDR, (k == 0) ? 32'h83e : 32'h0);
      apb(1'b1, snr_pkg::REG_CACHE_DATA, {24'h0, dat[47 - 8 * k -: 8]});
    end
    rdchk("fill ptr", snr_pkg::REG_CACHE_ADDR, 32'h3);
    n = oe_cnt;
    host.xfer(8'h6b, 24'h83e, 16, 1, 8, 4, 3, lr);
    chk("quad refused", n, oe_cnt);
    // cache reads across the spare end; entry 9 wraps with ecc off,
    // entries 10 and 11 are continuous modes that start at column 0
    for (k = 0; k < 12; k++) begin
      lk(8'h1f, {8'h0, 8'hb0, cfg[k]}, 16, 0);
      host.xfer(ops[k], (k >= 10) ? 24'h0 : 24'h83e, (k >= 10) ? 0 : 16, inl[k], dum[k],
                outl[k], 3, lr);
      chk("cache read", (k >= 10) ? {8'h0, dat[23:0]} : (k == 9) ?
          {8'h0, dat[47:32], dat[23:16]} : {8'h0, dat[47:24]}, lr);
    end
    rdchk("config", snr_pkg::REG_CONFIG, 32'h1d);
    finish_test();
  end
endmodule : testbench
